// File: verilog/spsd_port.sv
// Byte-wide synchronous serial port with control, status and data registers on APB.
// Assumes pins are asynchronous to pclk and a slave serial clock of at most pclk/4.
module spsd_port
  import spsd_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt.
  input wire logic int_ack,
  output logic irq,
  // Serial pins.
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_n_i
);
  logic [7:0] ctrl_reg;
  logic [7:0] shift_reg;
  logic [7:0] rx_buf_reg;
  logic [31:0] prdata_reg;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic [3:0] irq_clr;
  logic [3:0] edge_cnt_reg;
  logic [7:0] gap_reg;
  logic done_reg, write_collision_flag_reg, mode_fault_flag_reg, ovf_reg, rbf_reg;
  logic samp_reg, sck_prev_reg, sck_tog_reg;
  spsd_state_t state_reg;
  logic sel_ctrl, sel_stat, sel_data, sel_irqs, sel_mask, mapped;
  logic acc, wr_acc, rd_acc, rd_setup, st_wr, data_wr, data_rd;
  logic en, master_select, cpha, lsb_first_select, ss_low, mrun, slave_act, busy, load;
  logic tick, edge_ev, sample_now, shift_now, last, din, in_bit, byte_done, mode_fault_flag_set;
  logic [7:0] sh_shift;

  assign en = ctrl_reg[CTL_EN];
  assign master_select = ctrl_reg[CTL_MASTER_SELECT];
  assign cpha = ctrl_reg[CTL_CPHA];
  assign lsb_first_select = ctrl_reg[CTL_LSB_FIRST_SELECT];
  assign ss_low = !sync2_reg[3];

  // APB decode; the slave never waits and flags unmapped addresses.
  assign sel_ctrl = paddr[11:2] == IDX_CTRL;
  assign sel_stat = paddr[11:2] == IDX_STAT;
  assign sel_data = paddr[11:2] == IDX_DATA;
  assign sel_irqs = paddr[11:2] == IDX_IRQ_STAT;
  assign sel_mask = paddr[11:2] == IDX_IRQ_MASK;
  assign mapped = sel_ctrl | sel_stat | sel_data | sel_irqs | sel_mask;
  assign acc = psel && penable;
  assign wr_acc = acc && pwrite && mapped;
  assign rd_acc = acc && !pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign st_wr = wr_acc && sel_stat;
  assign data_wr = wr_acc && sel_data;
  assign data_rd = rd_acc && sel_data;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_reg;

  // Pin synchronisers: ss_n, sck, mosi, miso.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
    end else begin
      sync1_reg <= {ss_n_i, sck_i, mosi_i, miso_i};
      sync2_reg <= sync1_reg;
    end
  end

  // Slave activity follows the pin, or only the enable when the pin is ignored.
  assign slave_act = en && !master_select && (ctrl_reg[CTL_SLAVE_SELECT_IGNORE] || ss_low);
  assign mode_fault_flag_set = en && master_select && !ctrl_reg[CTL_SLAVE_SELECT_IGNORE] && ss_low;
  assign mrun = state_reg == SPSD_RUN;
  assign busy = mrun || slave_act;
  assign load = data_wr && !busy;

  spsd_sck_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(mrun),
    .rate(ctrl_reg[CTL_RATE_HI:CTL_RATE_LO]),
    .tick(tick)
  );

  // Edge events: divider ticks as master, synchronised clock changes as slave.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sync2_reg[2];
    end
  end
  assign edge_ev = mrun ? tick : (slave_act && (sync2_reg[2] != sck_prev_reg));
  assign sample_now = edge_ev && (cpha ? edge_cnt_reg[0] : !edge_cnt_reg[0]);
  assign last = edge_ev && (edge_cnt_reg == LAST_EDGE);
  assign shift_now = edge_ev && (cpha ? ((!edge_cnt_reg[0] && edge_cnt_reg != 4'h0) || last)
                                      : edge_cnt_reg[0]);
  assign din = master_select ? sync2_reg[0] : sync2_reg[1];
  assign in_bit = sample_now ? din : samp_reg;
  assign sh_shift = lsb_first_select ? {in_bit, shift_reg[7:1]} : {shift_reg[6:0], in_bit};
  assign byte_done = last;

  // Master transfer sequencer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SPSD_IDLE;
    end else begin
      case (state_reg)
        SPSD_IDLE: begin
          if (load && en && master_select && !mode_fault_flag_set) begin
            state_reg <= SPSD_RUN;
          end
        end
        SPSD_RUN: begin
          if (!en || !master_select || mode_fault_flag_set || last) begin
            state_reg <= SPSD_IDLE;
          end
        end
        default: begin
          state_reg <= SPSD_IDLE;
        end
      endcase
    end
  end

  // Edge counter and master clock level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_cnt_reg <= 4'h0;
      sck_tog_reg <= 1'b0;
    end else begin
      if (!busy || load) begin
        edge_cnt_reg <= 4'h0;
      end else if (edge_ev) begin
        edge_cnt_reg <= edge_cnt_reg + 4'h1;
      end
      if (!mrun) begin
        sck_tog_reg <= 1'b0;
      end else if (edge_ev) begin
        sck_tog_reg <= !sck_tog_reg;
      end
    end
  end

  // Shift register, sampled bit and receive buffer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= DATA_RST;
      samp_reg <= 1'b0;
      rx_buf_reg <= DATA_RST;
    end else begin
      if (load) begin
        shift_reg <= pwdata[7:0];
      end else if (shift_now) begin
        shift_reg <= sh_shift;
      end
      if (sample_now) begin
        samp_reg <= din;
      end
      if (byte_done && !rbf_reg) begin
        rx_buf_reg <= sh_shift;
      end
    end
  end

  // Control register; a mode fault drops enable and master select.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
    end else begin
      if (wr_acc && sel_ctrl) begin
        ctrl_reg <= pwdata[7:0];
      end
      if (mode_fault_flag_set) begin
        ctrl_reg[CTL_EN] <= 1'b0;
        ctrl_reg[CTL_MASTER_SELECT] <= 1'b0;
      end
    end
  end

  // Status flags; a set in the same cycle as a clear wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
      write_collision_flag_reg <= 1'b0;
      mode_fault_flag_reg <= 1'b0;
      ovf_reg <= 1'b0;
      rbf_reg <= 1'b0;
    end else begin
      done_reg <= byte_done || (done_reg && !int_ack && !(st_wr && !pwdata[ST_DONE]));
      write_collision_flag_reg <= (data_wr && busy) ||
                  (write_collision_flag_reg && !load && !(st_wr && !pwdata[ST_WRITE_COLLISION_FLAG]));
      mode_fault_flag_reg <= mode_fault_flag_set || (mode_fault_flag_reg && !(st_wr && !pwdata[ST_MODE_FAULT_FLAG]));
      ovf_reg <= (byte_done && rbf_reg) ||
                 (ovf_reg && !data_rd && !(st_wr && !pwdata[ST_OVF]));
      rbf_reg <= (byte_done && !rbf_reg) ||
                 (rbf_reg && !data_rd && !(st_wr && !pwdata[ST_RBF]));
    end
  end

  // Interrupt status clears on read of exactly the bits that were returned.
  assign irq_clr = (rd_acc && sel_irqs) ? prdata_reg[3:0] : 4'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 4'h0;
      irq_mask_reg <= MASK_RST;
    end else begin
      irq_stat_reg <= {byte_done && rbf_reg, mode_fault_flag_set,
                       data_wr && busy, byte_done} | (irq_stat_reg & ~irq_clr);
      if (wr_acc && sel_mask) begin
        irq_mask_reg <= pwdata[3:0];
      end
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Read data is captured in the setup phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      if (sel_ctrl) begin
        prdata_reg <= {24'h00_0000, ctrl_reg};
      end else if (sel_stat) begin
        prdata_reg <= {24'h00_0000, done_reg, write_collision_flag_reg, mode_fault_flag_reg, ovf_reg, rbf_reg, busy,
                       2'b00};
      end else if (sel_data) begin
        prdata_reg <= {24'h00_0000, rx_buf_reg};
      end else if (sel_irqs) begin
        prdata_reg <= {28'h000_0000, irq_stat_reg};
      end else if (sel_mask) begin
        prdata_reg <= {28'h000_0000, irq_mask_reg};
      end else begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  // Pin drivers.
  assign sck_o = ctrl_reg[CTL_CPOL] ^ sck_tog_reg;
  assign sck_oe = en && master_select;
  assign mosi_o = lsb_first_select ? shift_reg[0] : shift_reg[7];
  assign mosi_oe = en && master_select;
  assign miso_o = lsb_first_select ? shift_reg[0] : shift_reg[7];
  assign miso_oe = slave_act;

  // Helper: cycles since the last master edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_reg <= 8'h00;
    end else if (edge_ev || !mrun) begin
      gap_reg <= 8'h00;
    end else begin
      gap_reg <= gap_reg + 8'h01;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_data_wr;
    psel && penable && pwrite && sel_data;
  endsequence
  sequence s_data_rd_setup;
    psel && !penable && !pwrite && sel_data;
  endsequence

  a_ss_ignored: assert property (en && master_select && ctrl_reg[CTL_SLAVE_SELECT_IGNORE] |=> !$rose(mode_fault_flag_reg))
    else $error("Mode fault raised while slave select ignored.");
  a_sck_rate: assert property (mrun && edge_ev && edge_cnt_reg != 4'h0 |->
      gap_reg == 8'((9'h001 << ctrl_reg[CTL_RATE_HI:CTL_RATE_LO]) - 9'h001))
    else $error("Master clock edge spacing wrong.");
  a_mode_fault_flag_set: assert property (mode_fault_flag_set |=> mode_fault_flag_reg && !ctrl_reg[CTL_EN])
    else $error("Mode fault not flagged.");
  a_busy_hold: assert property ($rose(mrun) |-> busy [*8])
    else $error("Busy dropped early in a transfer.");
  a_start_load: assert property (s_data_wr ##0 (!busy && en && master_select && !mode_fault_flag_set)
      |=> mrun && shift_reg == $past(pwdata[7:0]))
    else $error("Data write did not start transfer.");
  a_read_buffer: assert property (s_data_rd_setup |=> prdata[7:0] == $past(rx_buf_reg))
    else $error("Data read not from receive buffer.");
  a_done_flag: assert property (byte_done |=> done_reg)
    else $error("Done flag not set at byte end.");
  a_write_collision_flag_drop: assert property (s_data_wr ##0 busy |=> write_collision_flag_reg && ($stable(shift_reg)
      || $past(shift_now)))
    else $error("Collision write not dropped.");
  a_overrun: assert property (byte_done && rbf_reg |=> ovf_reg && $stable(rx_buf_reg))
    else $error("Overrun not handled.");
  a_mode_fault_flag_off: assert property (mode_fault_flag_set |=> !ctrl_reg[CTL_MASTER_SELECT] && !mrun)
    else $error("Mode fault left port in master mode.");
endmodule : spsd_port

// File: verilog/spsd_pkg.sv
// Package of register indices, field positions and reset values for the serial port.
// Assumes a 32-bit register bus where each register index sits at byte address four times it.
package spsd_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_CTRL = 10'h0BC;
  localparam logic [9:0] IDX_STAT = 10'h0BD;
  localparam logic [9:0] IDX_DATA = 10'h0BE;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h0BF;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0C0;
  // Control register fields.
  localparam int CTL_EN = 7;
  localparam int CTL_MASTER_SELECT = 6;
  localparam int CTL_CPOL = 5;
  localparam int CTL_CPHA = 4;
  localparam int CTL_SLAVE_SELECT_IGNORE = 3;
  localparam int CTL_LSB_FIRST_SELECT = 2;
  localparam int CTL_RATE_HI = 1;
  localparam int CTL_RATE_LO = 0;
  // Status register fields.
  localparam int ST_DONE = 7;
  localparam int ST_WRITE_COLLISION_FLAG = 6;
  localparam int ST_MODE_FAULT_FLAG = 5;
  localparam int ST_OVF = 4;
  localparam int ST_RBF = 3;
  localparam int ST_BUSY = 2;
  // Interrupt status and mask fields.
  localparam int IRQ_DONE = 0;
  localparam int IRQ_WRITE_COLLISION_FLAG = 1;
  localparam int IRQ_MODE_FAULT_FLAG = 2;
  localparam int IRQ_OVF = 3;
  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] MASK_RST = 4'h0;
  // Sixteen clock edges make one byte.
  localparam logic [3:0] LAST_EDGE = 4'hF;
  typedef enum logic [1:0] {
    SPSD_IDLE = 2'b01,
    SPSD_RUN = 2'b10
  } spsd_state_t;
endpackage : spsd_pkg

// File: verilog/spsd_sck_div.sv
// Serial clock divider: one tick per half period of the master serial clock.
// Assumes run is a level from the port's own clock domain.
module spsd_sck_div
  import spsd_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic run,
  input wire logic [1:0] rate,
  // Half-period tick.
  output logic tick
);
  logic [3:0] cnt_reg;
  logic [3:0] lim;

  // A half period lasts two to the power of the rate code.
  assign lim = 4'((5'h01 << rate) - 5'h01);
  assign tick = run && (cnt_reg == lim);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 4'h0;
    end else if (!run || tick) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : spsd_sck_div

// File: verification/spsd_slave_model.sv
// Serial slave model on the far side of the port's master pins.
// Assumes clock mode 0: sample on the rising clock, shift on the falling clock.
module spsd_slave_model (
  // Serial pins.
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // Bench control.
  input wire logic sel,
  input wire logic lsb,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_reg = 8'h00;
  logic last_bit = 1'b0;
  initial rx_byte = 8'h00;
  always @(posedge sel) begin
    tx_reg = tx_byte;
  end
  always @(posedge sck) begin
    if (sel) begin
      rx_byte <= lsb ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
    end
  end
  always @(negedge sck) begin
    if (sel) begin
      tx_reg <= lsb ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
    end
  end
  // A released line shows the inverse of its last value.
  always @(tx_reg or sel or lsb) begin
    if (sel) begin
      last_bit = lsb ? tx_reg[0] : tx_reg[7];
    end
  end
  assign miso = sel ? last_bit : ~last_bit;
endmodule : spsd_slave_model

// File: verification/tb.sv
// Self-checking bench for the serial port: APB master, slave model, flag model.
// Assumes the port's top module and package as declared in the design.
module tb
  import spsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, int_ack = 0, ss_n = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, sck_o, mosi_o, miso, last_err, sck_q = 0, sp_sel = 0, sp_lsb = 0;
  logic [7:0] sp_tx = 8'h00, sp_rx, buf_m;
  int err_count = 0, cmp_count = 0, cyc = 0, edges = 0, gap = 0, last_e = 0, rbf_m = 0;
  bit buf_ok = 0;
  always #50 pclk = ~pclk;
  spsd_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .int_ack(int_ack), .irq(irq), .sck_i(1'b0), .sck_o(sck_o),
    .sck_oe(), .mosi_i(1'b0), .mosi_o(mosi_o), .mosi_oe(), .miso_i(miso), .miso_o(),
    .miso_oe(), .ss_n_i(ss_n));
  spsd_slave_model sp (.sck(sck_o), .mosi(mosi_o), .miso(miso), .sel(sp_sel), .lsb(sp_lsb),
    .tx_byte(sp_tx), .rx_byte(sp_rx));
  task finish_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    sck_q <= sck_o;
    if (sck_o !== sck_q) begin
      edges <= edges + 1;
      gap <= cyc - last_e;
      last_e <= cyc;
    end
    if (cyc == 40000) begin
      err_count++;
      finish_test();
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic [9:0] idx, input logic wr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) err_count++;
  endtask : apb
  task rd_data();
    apb(IDX_DATA, 1'b0, 32'h0);
    if (buf_ok) chk("data", rd, {24'h0, buf_m});
    rbf_m = 0;
    buf_ok = 0;
  endtask : rd_data
  task clean();
    rd_data();
    apb(IDX_STAT, 1'b1, 32'h0);
    apb(IDX_IRQ_STAT, 1'b0, 32'h0);
    apb(IDX_STAT, 1'b0, 32'h0);
    chk("status clean", rd, 32'h0);
  endtask : clean
  task automatic xfer(input logic [1:0] rate, input logic lsb, input logic coll);
    logic [7:0] mb, sb;
    int n, e0;
    mb = 8'($urandom);
    sb = 8'($urandom);
    sp_lsb <= lsb;
    sp_tx <= sb;
    apb(IDX_STAT, 1'b1, 32'h7F);
    apb(IDX_CTRL, 1'b1, {24'h0, 2'b11, 3'b000, lsb, rate});
    sp_sel <= 1'b1;
    e0 = edges;
    apb(IDX_DATA, 1'b1, {24'h0, mb});
    if (coll) apb(IDX_DATA, 1'b1, {24'h0, ~mb});
    n = 0;
    do begin
      apb(IDX_STAT, 1'b0, 32'h0);
      n++;
      if (rd[ST_DONE] !== 1'b1) chk("busy", {31'h0, rd[ST_BUSY]}, 32'h1);
    end while (rd[ST_DONE] !== 1'b1 && n < 200);
    chk("status", rd, {24'h0, 8'h88 | (coll ? 8'h40 : 8'h00) | (rbf_m ? 8'h10 : 8'h00)});
    chk("edges", 32'(edges - e0), 32'd16);
    chk("half period", 32'(gap), 32'(1 << rate));
    chk("slave rx", {24'h0, sp_rx}, {24'h0, mb});
    if (rbf_m == 0) begin
      buf_m = sb;
      buf_ok = (rate >= 2);
      rbf_m = 1;
    end
    sp_sel <= 1'b0;
    $display("transfer rate %0d lsb %0d done", rate, lsb);
  endtask : xfer
  initial begin
    void'($urandom(32'h806DFFF6));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(10'(IDX_CTRL + i), 1'b0, 32'h0);
      chk("reset value", rd, 32'h0);
    end
    apb(10'h0C1, 1'b0, 32'h0);
    chk("unmapped err", {31'h0, last_err}, 32'h1);
    apb(IDX_STAT, 1'b1, 32'hFF);
    apb(IDX_STAT, 1'b0, 32'h0);
    chk("status ones", rd, 32'h0);
    $display("registers done");
    ss_n <= 1'b0;
    apb(IDX_CTRL, 1'b1, 32'hC0);
    repeat (6) @(posedge pclk);
    apb(IDX_STAT, 1'b0, 32'h0);
    chk("mode fault", rd, 32'h20);
    apb(IDX_CTRL, 1'b0, 32'h0);
    chk("ctrl after fault", rd, 32'h0);
    clean();
    apb(IDX_CTRL, 1'b1, 32'hC8);
    repeat (6) @(posedge pclk);
    apb(IDX_STAT, 1'b0, 32'h0);
    chk("ss ignored", rd, 32'h0);
    ss_n <= 1'b1;
    clean();
    $display("mode fault done");
    for (int r = 0; r < 4; r++) begin
      for (int l = 0; l < 2; l++) begin
        xfer(2'(r), l[0], 1'b0);
        chk("irq masked", {31'h0, irq}, 32'h0);
        clean();
      end
    end
    xfer(2'd2, 1'b0, 1'b1);
    clean();
    xfer(2'd3, 1'b0, 1'b0);
    xfer(2'd3, 1'b1, 1'b0);
    rd_data();
    apb(IDX_STAT, 1'b0, 32'h0);
    chk("after overrun read", rd, 32'h80);
    clean();
    apb(IDX_IRQ_MASK, 1'b1, 32'h1);
    xfer(2'd2, 1'b1, 1'b0);
    chk("irq", {31'h0, irq}, 32'h1);
    @(posedge pclk);
    int_ack <= 1'b1;
    @(posedge pclk);
    int_ack <= 1'b0;
    apb(IDX_STAT, 1'b0, 32'h0);
    chk("vectored", rd, 32'h08);
    clean();
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("interrupt done");
    finish_test();
  end
endmodule : tb
